// ==== src/doorbell_pkg.sv ====
package doorbell_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int AW = 12;
  localparam int CW = 8;
  localparam int DW = 32;

  // ----------------------------------------
  // Agent side: local utilities block offsets
  // ----------------------------------------
  localparam logic [AW-1:0] LOC_IN_STAT_OFF  = 12'h100;
  localparam logic [AW-1:0] LOC_IN_MASK_OFF  = 12'h104;
  localparam logic [AW-1:0] LOC_IN_BELL_OFF  = 12'h120;
  localparam logic [AW-1:0] LOC_OUT_BELL_OFF = 12'h12C;

  // ----------------------------------------
  // Host side: PCI control/status block offsets
  // ----------------------------------------
  localparam logic [AW-1:0] PCI_IN_BELL_OFF  = 12'h020;
  localparam logic [AW-1:0] PCI_OUT_BELL_OFF = 12'h02C;
  localparam logic [AW-1:0] PCI_OUT_STAT_OFF = 12'h030;
  localparam logic [AW-1:0] PCI_OUT_MASK_OFF = 12'h034;

  // ----------------------------------------
  // Configuration space
  // ----------------------------------------
  localparam logic [CW-1:0] CFG_BASE_OFF = 8'h14;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int BELL_BIT = 3;
  localparam int MCHK_BIT = 4;
  localparam logic [DW-1:0] IN_SRC_BITS  = 32'h0000_0018;
  localparam logic [DW-1:0] OUT_SRC_BITS = 32'h0000_0008;
  localparam logic [DW-1:0] MASK_RST     = 32'hFFFF_FFFF;
  localparam logic [DW-1:0] ZERO_WORD    = 32'h0000_0000;

endpackage : doorbell_pkg

// ==== src/doorbell_message_unit.sv ====
`timescale 1ns/1ps
module doorbell_message_unit
  import doorbell_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          loc_req,
  input  wire logic          loc_we,
  input  wire logic [AW-1:0] loc_addr,
  input  wire logic [DW-1:0] loc_wdata,
  output logic      [DW-1:0] loc_rdata,
  output logic               loc_ack,
  input  wire logic          pci_req,
  input  wire logic          pci_we,
  input  wire logic [AW-1:0] pci_addr,
  input  wire logic [DW-1:0] pci_wdata,
  output logic      [DW-1:0] pci_rdata,
  output logic               pci_ack,
  input  wire logic          cfg_req,
  input  wire logic          cfg_we,
  input  wire logic [CW-1:0] cfg_addr,
  input  wire logic [DW-1:0] cfg_wdata,
  output logic      [DW-1:0] cfg_rdata,
  output logic               cfg_ack,
  input  wire logic          mchk_evt,
  output logic               agent_irq,
  output logic               inta_n
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [DW-1:0] gate(input logic en, input logic [DW-1:0] d);
    gate = en ? d : ZERO_WORD;
  endfunction : gate

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [DW-1:0] in_bell_ff,   nxt_in_bell;
  logic [DW-1:0] out_bell_ff,  nxt_out_bell;
  logic [DW-1:0] in_stat_ff,   nxt_in_stat;
  logic [DW-1:0] out_stat_ff,  nxt_out_stat;
  logic [DW-1:0] in_mask_ff,   nxt_in_mask;
  logic [DW-1:0] out_mask_ff,  nxt_out_mask;
  logic [DW-1:0] base_ff,      nxt_base;
  logic [DW-1:0] loc_rdata_ff, nxt_loc_rdata;
  logic [DW-1:0] pci_rdata_ff, nxt_pci_rdata;
  logic [DW-1:0] cfg_rdata_ff, nxt_cfg_rdata;
  logic          loc_ack_ff,   nxt_loc_ack;
  logic          pci_ack_ff,   nxt_pci_ack;
  logic          cfg_ack_ff,   nxt_cfg_ack;
  logic          irq_ff,       nxt_irq;
  logic          inta_n_ff,    nxt_inta_n;

  logic l_wr, l_rd, p_wr, p_rd;
  logic in_bell_wr_l, in_bell_wr_p, out_bell_wr_l, out_bell_wr_p;
  logic in_bell_rd, out_bell_rd, in_stat_rd, out_stat_rd;

  // ----------------------------------------
  // Access decode for both register windows
  // ----------------------------------------
  assign l_wr = loc_req & loc_we;
  assign l_rd = loc_req & ~loc_we;
  assign p_wr = pci_req & pci_we;
  assign p_rd = pci_req & ~pci_we;
  // Each doorbell answers in both windows
  assign in_bell_wr_l  = l_wr & hit(loc_addr, LOC_IN_BELL_OFF);
  assign in_bell_wr_p  = p_wr & hit(pci_addr, PCI_IN_BELL_OFF);
  assign out_bell_wr_l = l_wr & hit(loc_addr, LOC_OUT_BELL_OFF);
  assign out_bell_wr_p = p_wr & hit(pci_addr, PCI_OUT_BELL_OFF);
  assign in_bell_rd    = (l_rd & hit(loc_addr, LOC_IN_BELL_OFF)) | (p_rd & hit(pci_addr, PCI_IN_BELL_OFF));
  assign out_bell_rd   = (l_rd & hit(loc_addr, LOC_OUT_BELL_OFF)) | (p_rd & hit(pci_addr, PCI_OUT_BELL_OFF));
  assign in_stat_rd    = l_rd & hit(loc_addr, LOC_IN_STAT_OFF);
  assign out_stat_rd   = p_rd & hit(pci_addr, PCI_OUT_STAT_OFF);

  // ----------------------------------------
  // Doorbells, status and masks
  // ----------------------------------------
  // Writes OR in after the read-clear, so a ring in the same cycle is kept
  always_comb begin
    nxt_in_bell  = gate(!in_bell_rd, in_bell_ff) | gate(in_bell_wr_l, loc_wdata)
                 | gate(in_bell_wr_p, pci_wdata);
    nxt_out_bell = gate(!out_bell_rd, out_bell_ff) | gate(out_bell_wr_l, loc_wdata)
                 | gate(out_bell_wr_p, pci_wdata);
    nxt_in_stat  = gate(!in_stat_rd, in_stat_ff);
    nxt_out_stat = gate(!out_stat_rd, out_stat_ff);
    // Status sets regardless of the mask
    if (in_bell_wr_l || in_bell_wr_p) begin
      nxt_in_stat[BELL_BIT] = 1'b1;
    end
    if (mchk_evt) begin
      nxt_in_stat[MCHK_BIT] = 1'b1;
    end
    if (out_bell_wr_l || out_bell_wr_p) begin
      nxt_out_stat[BELL_BIT] = 1'b1;
    end
    nxt_in_mask  = in_mask_ff;
    nxt_out_mask = out_mask_ff;
    nxt_base     = base_ff;
    if (l_wr && hit(loc_addr, LOC_IN_MASK_OFF)) begin
      nxt_in_mask = loc_wdata;
    end
    if (p_wr && hit(pci_addr, PCI_OUT_MASK_OFF)) begin
      nxt_out_mask = pci_wdata;
    end
    if (cfg_req && cfg_we && cfg_addr == CFG_BASE_OFF) begin
      nxt_base = cfg_wdata;
    end
  end

  // ----------------------------------------
  // Interrupt outputs
  // ----------------------------------------
  // One cycle behind status; a mask bit set keeps the line quiet
  always_comb begin
    nxt_irq    = |(in_stat_ff & ~in_mask_ff & IN_SRC_BITS);
    nxt_inta_n = ~|(out_stat_ff & ~out_mask_ff & OUT_SRC_BITS);
  end

  // ----------------------------------------
  // Read data and acknowledge
  // ----------------------------------------
  // Unmapped addresses read as zero and are still acknowledged
  always_comb begin
    nxt_loc_ack   = loc_req;
    nxt_pci_ack   = pci_req;
    nxt_cfg_ack   = cfg_req;
    nxt_loc_rdata = ZERO_WORD;
    nxt_pci_rdata = ZERO_WORD;
    nxt_cfg_rdata = ZERO_WORD;
    if (l_rd) begin
      nxt_loc_rdata = gate(hit(loc_addr, LOC_IN_BELL_OFF), in_bell_ff)
                    | gate(hit(loc_addr, LOC_OUT_BELL_OFF), out_bell_ff)
                    | gate(hit(loc_addr, LOC_IN_STAT_OFF), in_stat_ff)
                    | gate(hit(loc_addr, LOC_IN_MASK_OFF), in_mask_ff);
    end
    if (p_rd) begin
      nxt_pci_rdata = gate(hit(pci_addr, PCI_IN_BELL_OFF), in_bell_ff)
                    | gate(hit(pci_addr, PCI_OUT_BELL_OFF), out_bell_ff)
                    | gate(hit(pci_addr, PCI_OUT_STAT_OFF), out_stat_ff)
                    | gate(hit(pci_addr, PCI_OUT_MASK_OFF), out_mask_ff);
    end
    if (cfg_req && !cfg_we && cfg_addr == CFG_BASE_OFF) begin
      nxt_cfg_rdata = base_ff;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Masks reset set so nothing fires before software is ready
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in_bell_ff   <= ZERO_WORD;
      out_bell_ff  <= ZERO_WORD;
      in_stat_ff   <= ZERO_WORD;
      out_stat_ff  <= ZERO_WORD;
      in_mask_ff   <= MASK_RST;
      out_mask_ff  <= MASK_RST;
      base_ff      <= ZERO_WORD;
      loc_rdata_ff <= ZERO_WORD;
      pci_rdata_ff <= ZERO_WORD;
      cfg_rdata_ff <= ZERO_WORD;
      loc_ack_ff   <= 1'b0;
      pci_ack_ff   <= 1'b0;
      cfg_ack_ff   <= 1'b0;
      irq_ff       <= 1'b0;
      inta_n_ff    <= 1'b1;
    end else begin
      in_bell_ff   <= nxt_in_bell;
      out_bell_ff  <= nxt_out_bell;
      in_stat_ff   <= nxt_in_stat;
      out_stat_ff  <= nxt_out_stat;
      in_mask_ff   <= nxt_in_mask;
      out_mask_ff  <= nxt_out_mask;
      base_ff      <= nxt_base;
      loc_rdata_ff <= nxt_loc_rdata;
      pci_rdata_ff <= nxt_pci_rdata;
      cfg_rdata_ff <= nxt_cfg_rdata;
      loc_ack_ff   <= nxt_loc_ack;
      pci_ack_ff   <= nxt_pci_ack;
      cfg_ack_ff   <= nxt_cfg_ack;
      irq_ff       <= nxt_irq;
      inta_n_ff    <= nxt_inta_n;
    end
  end

  assign loc_rdata = loc_rdata_ff;
  assign loc_ack   = loc_ack_ff;
  assign pci_rdata = pci_rdata_ff;
  assign pci_ack   = pci_ack_ff;
  assign cfg_rdata = cfg_rdata_ff;
  assign cfg_ack   = cfg_ack_ff;
  assign agent_irq = irq_ff;
  assign inta_n    = inta_n_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_in_mask_store: assert property (l_wr && hit(loc_addr, LOC_IN_MASK_OFF) |=>
    in_mask_ff == $past(loc_wdata)) else $error("inbound mask not stored");
  chk_out_mask_store: assert property (p_wr && hit(pci_addr, PCI_OUT_MASK_OFF) |=>
    out_mask_ff == $past(pci_wdata)) else $error("outbound mask not stored");
  chk_cfg_base_rd: assert property (cfg_req && !cfg_we && cfg_addr == CFG_BASE_OFF |=>
    cfg_ack && cfg_rdata == $past(base_ff)) else $error("config base readback wrong");
  chk_in_irq_rise: assert property (in_stat_ff[BELL_BIT] && !in_mask_ff[BELL_BIT] |=>
    agent_irq) else $error("inbound interrupt missing");
  chk_inta_active: assert property (out_stat_ff[BELL_BIT] && !out_mask_ff[BELL_BIT] |=>
    !inta_n) else $error("INTA not driven");
  chk_masked_quiet: assert property (!(|(in_stat_ff & ~in_mask_ff & IN_SRC_BITS)) |=>
    !agent_irq) else $error("agent interrupt while masked");
  chk_inta_quiet: assert property (!inta_n |-> $past(out_stat_ff[BELL_BIT] && !out_mask_ff[BELL_BIT]))
    else $error("INTA without unmasked cause");
  chk_in_latch: assert property (in_bell_wr_p |=> in_stat_ff[BELL_BIT]
    && (in_bell_ff & $past(pci_wdata)) == $past(pci_wdata)) else $error("inbound ring lost");
  chk_out_latch: assert property (out_bell_wr_l |=> out_stat_ff[BELL_BIT] ##1 out_stat_ff[BELL_BIT]
    || $past(out_stat_rd)) else $error("outbound ring lost");
  chk_in_clear: assert property (in_bell_rd && !in_bell_wr_l && !in_bell_wr_p |=>
    in_bell_ff == ZERO_WORD) else $error("inbound doorbell not cleared");
  chk_out_clear: assert property (out_bell_rd && !out_bell_wr_l && !out_bell_wr_p |=>
    out_bell_ff == ZERO_WORD) else $error("outbound doorbell not cleared");
  chk_full_word: assert property (out_bell_wr_l && out_bell_rd == 1'b0 && out_bell_ff == ZERO_WORD
    && !out_bell_wr_p |=> out_bell_ff == $past(loc_wdata)) else $error("doorbell word truncated");
  chk_in_stat_rd: assert property (in_stat_rd && !in_bell_wr_l && !in_bell_wr_p && !mchk_evt |=>
    in_stat_ff == ZERO_WORD && loc_ack && loc_rdata == $past(in_stat_ff)) else $error("inbound status not cleared");
  chk_out_stat_rd: assert property (out_stat_rd && !out_bell_wr_l && !out_bell_wr_p |=>
    pci_rdata == $past(out_stat_ff) && out_stat_ff == ZERO_WORD) else $error("outbound status read wrong");
  chk_mchk_alone: assert property (mchk_evt && !in_mask_ff[MCHK_BIT] && in_mask_ff[BELL_BIT] |=>
    in_stat_ff[MCHK_BIT] ##1 agent_irq) else $error("machine check not independent");
  chk_sticky: assert property (in_stat_ff[BELL_BIT] && !in_stat_rd |=> in_stat_ff[BELL_BIT])
    else $error("inbound status dropped");
  chk_out_sticky: assert property (out_stat_ff[BELL_BIT] && !out_stat_rd |=> out_stat_ff[BELL_BIT])
    else $error("outbound status dropped");

  // ----------------------------------------
  // Bus answer and window checks
  // ----------------------------------------
  // Every request is answered, mapped or not, so a master never hangs
  chk_loc_answer: assert property (loc_req |=> loc_ack)
    else $error("local request not answered");
  chk_pci_answer: assert property (pci_req |=> pci_ack)
    else $error("host request not answered");
  chk_cfg_base_store: assert property (cfg_req && cfg_we && cfg_addr == CFG_BASE_OFF |=>
    base_ff == $past(cfg_wdata)) else $error("config base not stored");
  // Rings from the opposite window land the same way
  chk_in_ring_loc: assert property (in_bell_wr_l |=> in_stat_ff[BELL_BIT]
    && (in_bell_ff & $past(loc_wdata)) == $past(loc_wdata)) else $error("local inbound ring lost");
  chk_out_ring_pci: assert property (out_bell_wr_p |=> out_stat_ff[BELL_BIT]
    && (out_bell_ff & $past(pci_wdata)) == $past(pci_wdata)) else $error("host outbound ring lost");
  // Read data shows the word held before the read-clear
  chk_in_bell_data: assert property (l_rd && hit(loc_addr, LOC_IN_BELL_OFF) |=>
    loc_rdata == $past(in_bell_ff)) else $error("inbound doorbell read wrong");
  chk_out_bell_data: assert property (p_rd && hit(pci_addr, PCI_OUT_BELL_OFF) |=>
    pci_rdata == $past(out_bell_ff)) else $error("outbound doorbell read wrong");
  // Mask readback in its own window only
  chk_in_mask_rd: assert property (l_rd && hit(loc_addr, LOC_IN_MASK_OFF) |=>
    loc_rdata == $past(in_mask_ff)) else $error("inbound mask readback wrong");
  chk_out_mask_rd: assert property (p_rd && hit(pci_addr, PCI_OUT_MASK_OFF) |=>
    pci_rdata == $past(out_mask_ff)) else $error("outbound mask readback wrong");
  // Masked outbound cause keeps the host line idle
  chk_inta_masked: assert property (!(out_stat_ff[BELL_BIT] && !out_mask_ff[BELL_BIT]) |=>
    inta_n) else $error("INTA active while masked");
  // Machine check latches whatever the doorbell mask says
  chk_mchk_set: assert property (mchk_evt |=> in_stat_ff[MCHK_BIT])
    else $error("machine check not latched");

  // Main scenarios the bench is expected to reach
  cov_host_rings: cover property (in_bell_wr_p ##2 agent_irq ##[1:20] in_bell_rd);
  cov_agent_rings: cover property (out_bell_wr_l ##2 !inta_n ##[1:20] out_stat_rd);
  cov_masked_ring: cover property (in_mask_ff[BELL_BIT] && in_bell_wr_p ##1 in_stat_ff[BELL_BIT]);
  cov_mchk_irq: cover property (mchk_evt && !in_mask_ff[MCHK_BIT] ##2 agent_irq);
  cov_out_masked: cover property (out_mask_ff[BELL_BIT] && out_bell_wr_l ##1 out_stat_ff[BELL_BIT]);

endmodule : doorbell_message_unit

// ==== verification/doorbell_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Host processor reaching the agent over PCI
// ----------------------------------------
module doorbell_host_model
  import doorbell_pkg::*;
(
  input  wire logic          core_clk,
  output logic               pci_req,
  output logic               pci_we,
  output logic      [AW-1:0] pci_addr,
  output logic      [DW-1:0] pci_wdata,
  input  wire logic [DW-1:0] pci_rdata,
  input  wire logic          pci_ack,
  output logic               cfg_req,
  output logic               cfg_we,
  output logic      [CW-1:0] cfg_addr,
  output logic      [DW-1:0] cfg_wdata,
  input  wire logic [DW-1:0] cfg_rdata,
  input  wire logic          cfg_ack
);
  logic          req;
  logic          sel;
  logic          we;
  logic [AW-1:0] a;
  logic [DW-1:0] d;

  // One request source shared by both windows; sel picks config space
  assign pci_req   = req & ~sel;
  assign cfg_req   = req & sel;
  assign pci_we    = we;
  assign cfg_we    = we;
  assign pci_addr  = a;
  assign cfg_addr  = a[CW-1:0];
  assign pci_wdata = d;
  assign cfg_wdata = d;

  // Bus idles with no request from time zero
  initial begin
    req = 1'b0;
    sel = 1'b0;
    we  = 1'b0;
    a   = '0;
    d   = '0;
  end

  // Single-cycle request, answer taken one edge later; host reads of bells and status clear them
  task automatic acc(input logic s, input logic w, input logic [AW-1:0] ad, input logic [DW-1:0] wd,
                     output logic [DW-1:0] rd, output logic ak);
    @(posedge core_clk);
    sel <= s;
    we  <= w;
    a   <= ad;
    d   <= wd;
    req <= 1'b1;
    @(posedge core_clk);
    req <= 1'b0;
    d   <= ~wd; // Released data must not look like a valid word
    #1;
    rd = s ? cfg_rdata : pci_rdata;
    ak = s ? cfg_ack : pci_ack;
  endtask : acc
endmodule : doorbell_host_model

// ==== verification/test_doorbell_message_unit.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp); \
    end \
  end
module test_doorbell_message_unit import doorbell_pkg::*;;
  logic          core_clk, rst_n, loc_req, loc_we, loc_ack, mchk_evt, agent_irq, inta_n;
  logic          pci_req, pci_we, pci_ack, cfg_req, cfg_we, cfg_ack;
  logic [AW-1:0] loc_addr, pci_addr;
  logic [CW-1:0] cfg_addr;
  logic [DW-1:0] loc_wdata, loc_rdata, pci_wdata, pci_rdata, cfg_wdata, cfg_rdata, rd;
  int            n_mismatch, n_tests;

  doorbell_message_unit uut (
    .core_clk(core_clk), .rst_n(rst_n), .mchk_evt(mchk_evt), .agent_irq(agent_irq), .inta_n(inta_n),
    .loc_req(loc_req), .loc_we(loc_we), .loc_addr(loc_addr), .loc_wdata(loc_wdata),
    .loc_rdata(loc_rdata), .loc_ack(loc_ack), .pci_req(pci_req), .pci_we(pci_we),
    .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_rdata(pci_rdata), .pci_ack(pci_ack),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

  doorbell_host_model host (
    .core_clk(core_clk), .pci_req(pci_req), .pci_we(pci_we), .pci_addr(pci_addr),
    .pci_wdata(pci_wdata), .pci_rdata(pci_rdata), .pci_ack(pci_ack), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack));

  // ----------------------------------------
  // Clock and bus tasks
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Agent access; request is a pulse, so it is dropped at the edge that takes it
  task automatic loc_acc(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk);
    loc_we    <= w;
    loc_addr  <= a;
    loc_wdata <= d;
    loc_req   <= 1'b1;
    @(posedge core_clk);
    loc_req   <= 1'b0;
    loc_wdata <= ~d;
    #1;
    rd = loc_rdata;
    `CHK(loc_ack, 1'b1);
  endtask : loc_acc

  task automatic lw(input logic [AW-1:0] a, input logic [DW-1:0] d);
    loc_acc(1'b1, a, d);
  endtask : lw

  task automatic lr(input logic [AW-1:0] a, input logic [DW-1:0] e);
    loc_acc(1'b0, a, ZERO_WORD);
    `CHK(rd, e);
  endtask : lr

  task automatic hacc(input logic s, input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic ak;
    host.acc(s, w, a, d, rd, ak);
    `CHK(ak, 1'b1);
  endtask : hacc

  task automatic hr(input logic s, input logic [AW-1:0] a, input logic [DW-1:0] e);
    hacc(s, 1'b0, a, ZERO_WORD);
    `CHK(rd, e);
  endtask : hr

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // Machine check pulse, taken at the second edge
  task automatic mchk();
    @(posedge core_clk);
    mchk_evt <= 1'b1;
    @(posedge core_clk);
    mchk_evt <= 1'b0;
    #1;
  endtask : mchk

  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Watchdog: the sequence needs about 120 cycles, so 5000 means a hang
  initial begin
    #(40 * 5000);
    n_mismatch++;
    results();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    n_mismatch = 0;
    n_tests    = 0;
    rst_n      = 1'b0;
    loc_req    = 1'b0;
    loc_we     = 1'b0;
    loc_addr   = '0;
    loc_wdata  = '0;
    mchk_evt   = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset state and configuration base
    lr(LOC_IN_MASK_OFF, MASK_RST);
    hr(1'b0, PCI_OUT_MASK_OFF, MASK_RST);
    hr(1'b1, AW'(CFG_BASE_OFF), ZERO_WORD);
    hacc(1'b1, 1'b1, AW'(CFG_BASE_OFF), 32'h8000_0000);
    hr(1'b1, AW'(CFG_BASE_OFF), 32'h8000_0000);
    lr(12'h200, ZERO_WORD);
    // Masked inbound ring: bits latch and accumulate, no interrupt
    hacc(1'b0, 1'b1, PCI_IN_BELL_OFF, 32'h8000_0001);
    hacc(1'b0, 1'b1, PCI_IN_BELL_OFF, 32'h0000_0F00);
    cyc(3);
    `CHK(agent_irq, 1'b0);
    lr(LOC_IN_STAT_OFF, 32'h0000_0008);
    lr(LOC_IN_STAT_OFF, ZERO_WORD);
    lr(LOC_IN_BELL_OFF, 32'h8000_0F01);
    lr(LOC_IN_BELL_OFF, ZERO_WORD);
    // Unmasked inbound ring: interrupt two cycles on, held until status read
    lw(LOC_IN_MASK_OFF, 32'hFFFF_FFF7);
    lr(LOC_IN_MASK_OFF, 32'hFFFF_FFF7);
    hacc(1'b0, 1'b1, PCI_IN_BELL_OFF, 32'hFFFF_FFFF);
    `CHK(agent_irq, 1'b0);
    cyc(1);
    `CHK(agent_irq, 1'b1);
    lw(LOC_IN_STAT_OFF, ZERO_WORD);
    cyc(4);
    `CHK(agent_irq, 1'b1);
    hr(1'b0, PCI_IN_BELL_OFF, 32'hFFFF_FFFF);
    lr(LOC_IN_BELL_OFF, ZERO_WORD);
    lr(LOC_IN_STAT_OFF, 32'h0000_0008);
    cyc(2);
    `CHK(agent_irq, 1'b0);
    // Machine check and doorbell enabled separately
    mchk();
    cyc(2);
    `CHK(agent_irq, 1'b0);
    lw(LOC_IN_MASK_OFF, 32'hFFFF_FFEF);
    hacc(1'b0, 1'b1, PCI_IN_BELL_OFF, 32'h0000_0004);
    cyc(2);
    `CHK(agent_irq, 1'b1);
    lr(LOC_IN_STAT_OFF, 32'h0000_0018);
    cyc(2);
    `CHK(agent_irq, 1'b0);
    // Machine check alone raises the agent line while the bell stays masked
    mchk();
    cyc(2);
    `CHK(agent_irq, 1'b1);
    lr(LOC_IN_STAT_OFF, 32'h0000_0010);
    // Outbound ring, masked then unmasked
    lw(LOC_OUT_BELL_OFF, 32'h0000_0002);
    cyc(3);
    `CHK(inta_n, 1'b1);
    hr(1'b0, PCI_OUT_STAT_OFF, 32'h0000_0008);
    hr(1'b0, PCI_OUT_STAT_OFF, ZERO_WORD);
    hacc(1'b0, 1'b1, PCI_OUT_MASK_OFF, 32'hFFFF_FFF7);
    hr(1'b0, PCI_OUT_MASK_OFF, 32'hFFFF_FFF7);
    lw(LOC_OUT_BELL_OFF, 32'h1234_5678);
    cyc(2);
    `CHK(inta_n, 1'b0);
    hr(1'b0, PCI_OUT_BELL_OFF, 32'h1234_567A);
    lr(LOC_OUT_BELL_OFF, ZERO_WORD);
    hacc(1'b0, 1'b1, PCI_OUT_BELL_OFF, 32'h0000_0100);
    lr(LOC_OUT_BELL_OFF, 32'h0000_0100);
    `CHK(inta_n, 1'b0);
    hr(1'b0, PCI_OUT_STAT_OFF, 32'h0000_0008);
    cyc(2);
    `CHK(inta_n, 1'b1);
    hacc(1'b0, 1'b1, PCI_OUT_MASK_OFF, MASK_RST);
    lw(LOC_OUT_BELL_OFF, 32'h0000_0001);
    cyc(3);
    `CHK(inta_n, 1'b1);
    results();
  end
endmodule : test_doorbell_message_unit
